// ==== hw/bwts_pkg.sv ====
// package of constants and types for the burst window transaction sequencer
package bwts_pkg;

  // sequence, mask, counter and rate widths
  localparam int SEQ_W  = 5;
  localparam int MASK_W = 32;
  localparam int CNT_W  = 6;
  localparam int RATE_W = 4;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] CFG_OFF    = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] RXWIN_OFF  = 8'h0C;
  localparam logic [7:0] TXWIN_OFF  = 8'h10;

  // control register fields
  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_CFGEV_BIT = 1;

  // config register fields
  localparam int CFG_BURST_LSB = 0;
  localparam int CFG_MAXSEQ_LSB = 8;
  localparam int CFG_NBUF_LSB = 16;

  // status register fields
  localparam int ST_LO_LSB = 0;
  localparam int ST_OCC_LSB = 8;
  localparam int ST_STATE_LSB = 16;

  // reset values
  localparam logic [CNT_W-1:0] BURST_RST  = 6'h04;
  localparam logic [CNT_W-1:0] MAXSEQ_RST = 6'h0A;
  localparam logic [CNT_W-1:0] NBUF_RST   = 6'h04;
  // windows open the first burst of slots at reset, matching the default burst
  localparam logic [MASK_W-1:0] WIN_RST   = 32'h0000_000F;

  // bit rate code used for scheduling and handshake packets
  localparam logic [RATE_W-1:0] RATE_BASE = 4'h0;

  // what the endpoint sends at slot start
  typedef enum logic [1:0] {
    BWTS_TX_DATA  = 2'h0,
    BWTS_TX_ACK   = 2'h1,
    BWTS_TX_NAK   = 2'h2,
    BWTS_TX_STALL = 2'h3
  } bwts_kind_t;

  // transaction phase states
  typedef enum logic [2:0] {
    BWTS_IDLE    = 3'h1,
    BWTS_IN_WAIT = 3'h2,
    BWTS_HS_WAIT = 3'h4
  } bwts_state_t;

endpackage

// ==== hw/bwts_seq.sv ====
// endpoint burst window and transaction phase sequencer with apb registers
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module bwts_seq (
  input  wire logic                          pclk,             // protocol clock, 100 MHz
  input  wire logic                          presetn,          // async reset, active low
  input  wire logic                          psel,             // apb select
  input  wire logic                          penable,          // apb access phase
  input  wire logic                          pwrite,           // apb write
  input  wire logic [7:0]                    paddr,            // apb byte address
  input  wire logic [31:0]                   pwdata,           // apb write data
  output logic      [31:0]                   prdata,           // apb read data
  output logic                               pready,           // apb ready
  output logic                               pslverr,          // apb error, unmapped
  input  wire logic                          tok_valid,        // slot block decoded, pulse
  input  wire logic                          tok_err,          // scheduling packet had error
  input  wire logic                          tok_xmit,         // device_transmit_slot_block
  input  wire logic                          tok_hs,           // transmit block is out handshake
  input  wire logic                          tok_blank,        // block allocates no time
  input  wire logic [bwts_pkg::MASK_W-1:0]   inbound_ack_bitmask, // host receive window
  input  wire logic [bwts_pkg::RATE_W-1:0]   tok_rate,         // data bit rate code
  input  wire logic                          slot_start,       // allocated slot begins, pulse
  input  wire logic                          rx_valid,         // data packet landed, pulse
  input  wire logic [bwts_pkg::SEQ_W-1:0]    rx_seq,           // its sequence number
  input  wire logic                          buf_release,      // app freed one buffer, pulse
  input  wire logic                          tx_have_data,     // in data pending
  output logic                               tx_go,            // start sending, pulse
  output bwts_pkg::bwts_kind_t               tx_kind,          // data, ack, nak or stall
  output logic      [bwts_pkg::RATE_W-1:0]   tx_rate,          // bit rate code to use
  output logic      [bwts_pkg::MASK_W-1:0]   tx_mask,          // data window or ack mask
  output logic      [bwts_pkg::SEQ_W-1:0]    rx_deliver_seq,   // in-order sequence delivered
  output logic                               rx_deliver        // delivery strobe, pulse
);
  import bwts_pkg::*;

  // modular increment of a sequence value
  function automatic logic [SEQ_W-1:0] seq_inc(input logic [SEQ_W-1:0] s, input logic [CNT_W-1:0] maxseq);
    logic [CNT_W-1:0] t;
    t = {1'b0, s} + 6'h01;
    if (t >= maxseq) t = 6'h00;
    seq_inc = t[SEQ_W-1:0];
  endfunction

  // receive window: free slots from lo, skipping landed ones, inside the distance limit
  function automatic logic [MASK_W-1:0] win_mask(input logic [SEQ_W-1:0] lo, input logic [MASK_W-1:0] got,
                                                  input logic [CNT_W-1:0] nslots, input logic [CNT_W-1:0] maxseq);
    logic [CNT_W-1:0] v;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] maxdist;
    win_mask = '0;
    cnt      = 6'h00;
    maxdist  = maxseq - 6'h01;
    for (int i = 0; i < MASK_W; i++) begin
      v = {1'b0, lo} + 6'(i);
      if (v >= maxseq) v = v - maxseq;
      if (6'(i) < maxdist && cnt < nslots && !got[v[SEQ_W-1:0]]) begin
        win_mask[v[SEQ_W-1:0]] = 1'b1;
        cnt = cnt + 6'h01;
      end
    end
  endfunction

  // register state
  logic                halt_reg,   halt_next;
  logic [CNT_W-1:0]    burst_reg,  burst_next;
  logic [CNT_W-1:0]    maxseq_reg, maxseq_next;
  logic [CNT_W-1:0]    nbuf_reg,   nbuf_next;
  logic [31:0]         prdata_reg, prdata_next;
  logic                pready_reg, pready_next;
  logic                pserr_reg,  pserr_next;
  logic                cfg_ev;
  // window and phase state
  bwts_state_t         state_reg,  state_next;
  logic [SEQ_W-1:0]    lo_reg,     lo_next;
  logic [MASK_W-1:0]   got_reg,    got_next;
  logic [CNT_W-1:0]    occ_reg,    occ_next;
  logic [MASK_W-1:0]   rx_win_reg, rx_win_next;
  logic [MASK_W-1:0]   tx_win_reg, tx_win_next;
  logic [RATE_W-1:0]   rate_reg,   rate_next;
  logic                go_reg,     go_next;
  bwts_kind_t          kind_reg,   kind_next;
  logic [RATE_W-1:0]   txr_reg,    txr_next;
  logic [MASK_W-1:0]   txm_reg,    txm_next;
  logic                dlv_reg,    dlv_next;
  logic [SEQ_W-1:0]    dseq_reg,   dseq_next;
  logic [CNT_W-1:0]    avail;
  logic [CNT_W-1:0]    nslots;
  logic                accept;

  // apb slave: decode in setup cycle so prdata is a flop in the access cycle
  always_comb begin
    halt_next   = halt_reg;
    burst_next  = burst_reg;
    maxseq_next = maxseq_reg;
    nbuf_next   = nbuf_reg;
    prdata_next = prdata_reg;
    pserr_next  = 1'b0;
    pready_next = psel & ~penable;
    cfg_ev      = 1'b0;
    if (psel && !penable) begin
      prdata_next = 32'h0000_0000;
      if (paddr == CTRL_OFF) begin
        prdata_next[CTRL_HALT_BIT] = halt_reg;
      end else if (paddr == CFG_OFF) begin
        prdata_next = {10'h000, nbuf_reg, 2'h0, maxseq_reg, 2'h0, burst_reg};
      end else if (paddr == STATUS_OFF) begin
        prdata_next = {13'h0000, state_reg, 2'h0, occ_reg, 3'h0, lo_reg};
      end else if (paddr == RXWIN_OFF) begin
        prdata_next = rx_win_reg;
      end else if (paddr == TXWIN_OFF) begin
        prdata_next = tx_win_reg;
      end else begin
        pserr_next = 1'b1;
      end
    end
    // writes take effect at the access edge
    if (psel && penable && pwrite) begin
      if (paddr == CTRL_OFF) begin
        halt_next = pwdata[CTRL_HALT_BIT];
        cfg_ev    = pwdata[CTRL_CFGEV_BIT];
      end else if (paddr == CFG_OFF) begin
        burst_next  = pwdata[CFG_BURST_LSB +: CNT_W];
        maxseq_next = pwdata[CFG_MAXSEQ_LSB +: CNT_W];
        nbuf_next   = pwdata[CFG_NBUF_LSB +: CNT_W];
      end
    end
  end

  // free buffers bound the window; none free gives an empty ack
  always_comb begin
    avail  = (occ_reg >= nbuf_reg) ? 6'h00 : nbuf_reg - occ_reg;
    nslots = (avail < burst_reg) ? avail : burst_reg;
    accept = rx_valid && rx_win_reg[rx_seq] && avail != 6'h00;
  end

  // window tracking and transaction phases
  always_comb begin
    state_next  = state_reg;
    lo_next     = lo_reg;
    got_next    = got_reg;
    occ_next    = occ_reg;
    tx_win_next = tx_win_reg;
    rate_next   = rate_reg;
    go_next     = 1'b0;
    kind_next   = kind_reg;
    txr_next    = txr_reg;
    txm_next    = txm_reg;
    dlv_next    = 1'b0;
    dseq_next   = dseq_reg;
    // a landed packet holds a buffer until the application frees it
    if (accept) got_next[rx_seq] = 1'b1;
    occ_next = occ_reg + {5'h00, accept} - {5'h00, buf_release};
    // deliver in order; stuck lo keeps the window over the gap
    if (got_reg[lo_reg]) begin
      got_next[lo_reg] = accept && rx_seq == lo_reg;
      lo_next          = seq_inc(lo_reg, maxseq_reg);
      dlv_next         = 1'b1;
      dseq_next        = lo_reg;
    end
    // sliding receive window, recomputed every cycle
    rx_win_next = win_mask(lo_reg, got_reg, nslots, maxseq_reg);
    case (state_reg)
      BWTS_IDLE: begin
        if (tok_valid && !tok_err && tok_xmit) begin
          if (tok_hs) begin
            state_next = tok_blank ? BWTS_IDLE : BWTS_HS_WAIT;
          end else begin
            tx_win_next = inbound_ack_bitmask;
            rate_next   = tok_rate;
            state_next  = tok_blank ? BWTS_IDLE : BWTS_IN_WAIT;
          end
        end
      end
      BWTS_IN_WAIT: begin
        if (tok_valid && tok_err) begin
          state_next = BWTS_IDLE;
        end else if (slot_start) begin
          go_next    = 1'b1;
          state_next = BWTS_IDLE;
          if (halt_reg) begin
            kind_next = BWTS_TX_STALL;
            txr_next  = RATE_BASE;
            txm_next  = '0;
          end else if (tx_have_data && tx_win_reg != '0) begin
            kind_next = BWTS_TX_DATA;
            txr_next  = rate_reg;
            txm_next  = tx_win_reg;
          end else begin
            kind_next = BWTS_TX_NAK;
            txr_next  = RATE_BASE;
            txm_next  = '0;
          end
        end
      end
      BWTS_HS_WAIT: begin
        if (tok_valid && tok_err) begin
          state_next = BWTS_IDLE;
        end else if (slot_start) begin
          go_next    = 1'b1;
          state_next = BWTS_IDLE;
          txr_next   = RATE_BASE;
          kind_next  = halt_reg ? BWTS_TX_STALL : BWTS_TX_ACK;
          txm_next   = halt_reg ? '0 : rx_win_reg;
        end
      end
      default: state_next = BWTS_IDLE;
    endcase
    // configuration event overrides phase state, tracking and the transmit window, not tx_go or delivery; restart at sequence zero
    if (cfg_ev) begin
      state_next  = BWTS_IDLE;
      lo_next     = '0;
      got_next    = '0;
      occ_next    = 6'h00;
      tx_win_next = (32'h0000_0001 << burst_reg) - 32'h0000_0001;
    end
  end

  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_reg   <= 1'b0;
      burst_reg  <= BURST_RST;
      maxseq_reg <= MAXSEQ_RST;
      nbuf_reg   <= NBUF_RST;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pserr_reg  <= 1'b0;
      state_reg  <= BWTS_IDLE;
      lo_reg     <= '0;
      got_reg    <= '0;
      occ_reg    <= 6'h00;
      rx_win_reg <= WIN_RST;
      tx_win_reg <= WIN_RST;
      rate_reg   <= RATE_BASE;
      go_reg     <= 1'b0;
      kind_reg   <= BWTS_TX_NAK;
      txr_reg    <= RATE_BASE;
      txm_reg    <= '0;
      dlv_reg    <= 1'b0;
      dseq_reg   <= '0;
    end else begin
      halt_reg   <= halt_next;
      burst_reg  <= burst_next;
      maxseq_reg <= maxseq_next;
      nbuf_reg   <= nbuf_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pserr_reg  <= pserr_next;
      state_reg  <= state_next;
      lo_reg     <= lo_next;
      got_reg    <= got_next;
      occ_reg    <= occ_next;
      rx_win_reg <= rx_win_next;
      tx_win_reg <= tx_win_next;
      rate_reg   <= rate_next;
      go_reg     <= go_next;
      kind_reg   <= kind_next;
      txr_reg    <= txr_next;
      txm_reg    <= txm_next;
      dlv_reg    <= dlv_next;
      dseq_reg   <= dseq_next;
    end
  end

  // outputs straight from flops
  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pserr_reg;  // only a setup cycle sets it, so it rises with pready
  assign tx_go          = go_reg;
  assign tx_kind        = kind_reg;
  assign tx_rate        = txr_reg;
  assign tx_mask        = txm_reg;
  assign rx_deliver     = dlv_reg;
  assign rx_deliver_seq = dseq_reg;

  // good in token followed by its slot
  sequence in_token_s;
    tok_valid && !tok_err && tok_xmit && !tok_hs && !tok_blank && state_reg == BWTS_IDLE && !cfg_ev;
  endsequence

  sequence slot_now_s;
    slot_start && !tok_valid;
  endsequence

  property in_answer_p;
    @(posedge pclk) disable iff (!presetn)
    in_token_s ##1 (!tok_valid && !cfg_ev) ##1 slot_now_s |=>
      tx_go && (tx_kind != BWTS_TX_DATA || tx_rate == $past(tok_rate, 3));
  endproperty

  // checks
  in_data_rate_a: assert property (in_answer_p) else $error("in slot answer missing or wrong rate");
  hs_base_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_go && tx_kind != BWTS_TX_DATA |-> tx_rate == RATE_BASE) else $error("handshake not at base rate");
  tx_win_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_token_s |=> tx_win_reg == $past(inbound_ack_bitmask)) else $error("transmit window not reloaded");
  tx_win_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    tok_valid && tok_err && !cfg_ev |=> $stable(tx_win_reg)) else $error("window moved without handshake");
  err_silent_a: assert property (@(posedge pclk) disable iff (!presetn)
    tok_valid && tok_err && state_reg != BWTS_IDLE |=> !tx_go ##1 !tx_go) else $error("answered bad scheduling packet");
  blank_no_tx_a: assert property (@(posedge pclk) disable iff (!presetn)
    tok_valid && !tok_err && tok_blank && state_reg == BWTS_IDLE |=> state_reg == BWTS_IDLE ##1 !tx_go) else $error("blank block sent");
  full_empty_win_a: assert property (@(posedge pclk) disable iff (!presetn)
    occ_reg >= nbuf_reg |=> rx_win_reg == '0) else $error("window open with no free buffer");
  outside_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_valid && !rx_win_reg[rx_seq] && !buf_release && !cfg_ev |=> occ_reg == $past(occ_reg)) else $error("outside packet kept");
  cfg_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ev |=> lo_reg == '0 && occ_reg == 6'h00 && state_reg == BWTS_IDLE) else $error("config event did not restart");
  win_distance_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 !$past(cfg_ev) && $stable(maxseq_reg) |-> (rx_win_reg & ~((32'h0000_0001 << $past(maxseq_reg)) - 32'h0000_0001)) == '0)
    else $error("window past max sequence");
endmodule

// ==== bench/bwts_host_model.sv ====
// host controller model that schedules slot blocks and sends out data
`timescale 1ns/1ps
module bwts_host_model (
  input  wire logic                        pclk,                // protocol clock
  input  wire logic                        tx_go,               // endpoint send strobe
  input  wire bwts_pkg::bwts_kind_t        tx_kind,             // endpoint send kind
  input  wire logic [bwts_pkg::MASK_W-1:0] tx_mask,             // endpoint ack mask
  output logic                             tok_valid,           // slot block strobe
  output logic                             tok_err,             // block corrupted
  output logic                             tok_xmit,            // transmit block
  output logic                             tok_hs,              // out handshake block
  output logic                             tok_blank,           // no time allocated
  output logic [bwts_pkg::MASK_W-1:0]      inbound_ack_bitmask, // host receive window
  output logic [bwts_pkg::RATE_W-1:0]      tok_rate,            // data rate code
  output logic                             slot_start,          // slot begins
  output logic                             rx_valid,            // out packet strobe
  output logic [bwts_pkg::SEQ_W-1:0]       rx_seq,              // out packet sequence
  output logic                             flow_paused          // out scheduling stopped
);
  import bwts_pkg::*;

  // quiet lines at time zero
  initial begin
    {tok_valid, tok_err, tok_xmit, tok_hs, tok_blank, slot_start, rx_valid, flow_paused} = 8'h00;
    inbound_ack_bitmask = 32'h0;
    tok_rate = 4'h0;
    rx_seq = 5'h0;
  end

  // one slot block; data lines flip afterwards so stale values never pass as valid
  task automatic token(input logic x, input logic h, input logic b, input logic e,
                       input logic [MASK_W-1:0] mk, input logic [RATE_W-1:0] r);
    @(posedge pclk);
    tok_valid           <= 1'b1;
    tok_xmit            <= x;
    tok_hs              <= h;
    tok_blank           <= b;
    tok_err             <= e;
    inbound_ack_bitmask <= mk;
    tok_rate            <= r;
    @(posedge pclk);
    tok_valid           <= 1'b0;
    inbound_ack_bitmask <= ~mk;
    tok_rate            <= ~r;
  endtask

  // start of the allocated slot
  task automatic slot();
    @(posedge pclk);
    slot_start <= 1'b1;
    @(posedge pclk);
    slot_start <= 1'b0;
  endtask

  // out data packet, then a gap so the receive window can settle
  task automatic pkt(input logic [SEQ_W-1:0] s);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_seq   <= s;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_seq   <= ~s;
    @(posedge pclk);
  endtask

  // handshake phase only, repeated as often as the caller needs
  task automatic out_hs();
    token(1'b1, 1'b1, 1'b0, 1'b0, 32'h0, RATE_BASE);
    slot();
  endtask

  // an all-zero ack takes the endpoint out of the out schedule
  always @(posedge pclk) if (tx_go && tx_kind == BWTS_TX_ACK) flow_paused <= (tx_mask == 32'h0);
endmodule

// ==== bench/burst_window_transaction_seq_test.sv ====
// self-checking bench for the burst window transaction sequencer
`timescale 1ns/1ps
module burst_window_transaction_seq_test;
  import bwts_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic              buf_release = 1'b0;
  logic              tx_have_data = 1'b0;
  logic [31:0]       prdata, rd, perr, m;
  logic              pready, pslverr, tx_go, rx_deliver;
  logic              tok_valid, tok_err, tok_xmit, tok_hs, tok_blank, slot_start, rx_valid, flow_paused;
  logic [MASK_W-1:0] inbound_ack_bitmask, tx_mask;
  logic [MASK_W-1:0] got = 32'h0;
  logic [RATE_W-1:0] tok_rate, tx_rate;
  logic [SEQ_W-1:0]  rx_seq, rx_deliver_seq;
  bwts_kind_t        tx_kind;
  integer            seed = 32'hE4CC;
  int                miscompares = 0;
  int                samples_checked = 0;
  int                go_cnt = 0, dcnt = 0, dseq = 0, lo = 0, occ = 0, nbuf = 4, maxseq = 10, burst = 4, g;
  int                grp [4][3] = '{'{1, 2, 3}, '{4, 5, 6}, '{7, 8, -1}, '{0, -1, -1}};

  always #5 pclk = ~pclk;

  bwts_seq dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tok_valid, .tok_err, .tok_xmit, .tok_hs, .tok_blank, .inbound_ack_bitmask, .tok_rate, .slot_start,
    .rx_valid, .rx_seq, .buf_release, .tx_have_data, .tx_go, .tx_kind, .tx_rate, .tx_mask,
    .rx_deliver_seq, .rx_deliver);
  bwts_host_model host (.pclk, .tx_go, .tx_kind, .tx_mask, .tok_valid, .tok_err, .tok_xmit, .tok_hs,
    .tok_blank, .inbound_ack_bitmask, .tok_rate, .slot_start, .rx_valid, .rx_seq, .flow_paused);

  task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
    samples_checked++;
    if (gv !== ev) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, gv, ev);
    end
  endtask

  task automatic complete_run();
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one apb transfer; the wait for pready is bounded
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    rd      = prdata;
    perr    = {31'h0, pslverr};
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // receive window the endpoint should offer: free slots from lo, capped by burst, buffers and distance
  function automatic logic [31:0] exp_win();
    logic [31:0] w;
    int n;
    w = 32'h0;
    n = 0;
    for (int k = 0; k < maxseq - 1; k++)
      if (!got[(lo + k) % maxseq] && n < burst && n < nbuf - occ) begin
        w[(lo + k) % maxseq] = 1'b1;
        n++;
      end
    return w;
  endfunction

  // send one out packet and track what the endpoint should keep
  task automatic send(input int s);
    m = exp_win();
    host.pkt(s[SEQ_W-1:0]);
    if (m[s]) begin
      got[s] = 1'b1;
      occ++;
      while (got[lo]) begin
        got[lo] = 1'b0;
        lo = (lo + 1) % maxseq;
      end
    end
  endtask

  // handshake slot of an out transfer; deliveries get time to drain first
  task automatic ack_chk();
    repeat (12) @(posedge pclk);
    g = go_cnt;
    host.out_hs();
    repeat (3) @(posedge pclk);
    chk(go_cnt - g, 1);
    chk(32'(tx_kind), 32'(BWTS_TX_ACK));
    chk(32'(tx_rate), 32'(RATE_BASE));
    chk(tx_mask, exp_win());
  endtask

  // in transfer: token reloads the transmit window, then the slot answer
  task automatic in_xfer(input logic [31:0] mk, input logic [3:0] r, input logic have, input logic halt);
    bwts_kind_t k;
    k = halt ? BWTS_TX_STALL : (have && mk != 32'h0) ? BWTS_TX_DATA : BWTS_TX_NAK;
    apb(1'b1, CTRL_OFF, {31'h0, halt});
    tx_have_data <= have;
    g = go_cnt;
    host.token(1'b1, 1'b0, 1'b0, 1'b0, mk, r);
    host.slot();
    repeat (3) @(posedge pclk);
    chk(go_cnt - g, 1);
    chk(32'(tx_kind), 32'(k));
    chk(32'(tx_rate), (k == BWTS_TX_DATA) ? 32'(r) : 32'(RATE_BASE));
    if (k == BWTS_TX_DATA) chk(tx_mask, mk);
    rdchk(TXWIN_OFF, mk);
  endtask

  // count send strobes and check delivery order
  always @(posedge pclk) begin
    if (tx_go === 1'b1) go_cnt <= go_cnt + 1;
    if (rx_deliver === 1'b1) begin
      chk(32'(rx_deliver_seq), dseq);
      dseq = (dseq + 1) % maxseq;
      dcnt++;
    end
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(CFG_OFF, 32'h0004_0A04);
    rdchk(STATUS_OFF, 32'h0001_0000);
    rdchk(RXWIN_OFF, 32'h0000_000F);
    rdchk(TXWIN_OFF, 32'h0000_000F);
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk(perr, 32'h1);
    rdchk(8'h40, 32'h0);
    chk(perr, 32'h1);
    // random in transfers, first with an empty window, last while halted
    for (int i = 0; i < 6; i++) begin
      m = (i == 0) ? 32'h0 : ($random(seed) & 32'h3FF);
      in_xfer(m, 4'($random(seed)), (i != 1), (i == 5));
    end
    // blank block applies the mask and allocates nothing
    g = go_cnt;
    host.token(1'b1, 1'b0, 1'b1, 1'b0, 32'h0000_00F0, 4'h3);
    repeat (4) @(posedge pclk);
    chk(go_cnt - g, 0);
    rdchk(TXWIN_OFF, 32'h0000_00F0);
    // corrupted scheduling packet while a slot is pending: silent slot, window kept
    host.token(1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_00F0, 4'h5);
    host.token(1'b1, 1'b0, 1'b0, 1'b1, 32'h0000_0003, 4'h5);
    host.slot();
    repeat (4) @(posedge pclk);
    chk(go_cnt - g, 0);
    rdchk(TXWIN_OFF, 32'h0000_00F0);
    apb(1'b1, CTRL_OFF, 32'h2);
    rdchk(TXWIN_OFF, 32'h0000_000F);
    // out flow control with four buffers; seq 5 lies outside the window
    host.token(1'b0, 1'b0, 1'b0, 1'b0, 32'h0, RATE_BASE);
    send(5);
    send(0);
    send(1);
    repeat (2) ack_chk();
    send(2);
    send(3);
    ack_chk();
    chk(32'(flow_paused), 32'h1);
    repeat (4) begin
      @(posedge pclk);
      buf_release <= 1'b1;
      @(posedge pclk);
      buf_release <= 1'b0;
    end
    occ = 0;
    repeat (3) @(posedge pclk);
    rdchk(RXWIN_OFF, exp_win());
    chk(dcnt, 4);
    // stuck packet zero up to the distance limit, then recovery
    apb(1'b1, CFG_OFF, 32'h0010_0A04);
    apb(1'b1, CTRL_OFF, 32'h2);
    nbuf = 16;
    lo = 0;
    occ = 0;
    dseq = 0;
    dcnt = 0;
    got = 32'h0;
    rdchk(RXWIN_OFF, 32'h0000_000F);
    for (int i = 0; i < 4; i++) begin
      host.token(1'b0, 1'b0, 1'b0, 1'b0, 32'h0, RATE_BASE);
      for (int j = 0; j < 3; j++)
        if (grp[i][j] >= 0) send(grp[i][j]);
      ack_chk();
    end
    chk(dcnt, 9);
    rdchk(STATUS_OFF, 32'h0001_0909);
    complete_run();
  end

  // hang guard, far beyond the expected run
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
endmodule
